// ### src/overtravel_map.vh
/*
 Register offsets, field positions, reset values and stop behaviour codes for the
 overtravel and stop control block. Assumes inclusion by bare name.
*/
`ifndef OVERTRAVEL_MAP_VH
`define OVERTRAVEL_MAP_VH

// Register byte offsets
`define OFF_DIRECTION     4'h0
`define OFF_LIMIT_MAP     4'h4
`define OFF_STOP_MODE     4'h8
`define OFF_ESTOP_TORQUE  4'hC

// Digit fields
`define DIGIT_W           4
`define LMAP_FWD_LSB      0
`define LMAP_REV_LSB      4
`define SMODE_OFF_LSB     0
`define SMODE_OT_LSB      4

// Reset values and the unused-limit map code
`define RST_DIRECTION     4'h0
`define RST_FWD_MAP       4'h2
`define RST_REV_MAP       4'h3
`define LIMIT_UNUSED      4'h8
`define RST_OT_MODE       4'h0
`define RST_OFF_MODE      4'h0
`define RST_ESTOP_TORQUE  16'h0320

// Stop behaviours
`define OT_SERVO_OFF      4'h0
`define OT_DECEL_CLAMP    4'h1
`define OT_DECEL_COAST    4'h2
`define OFF_DB_HOLD       4'h0
`define OFF_DB_COAST      4'h1
`define OFF_COAST         4'h2

// Status read-back offset
`define OFF_STATUS        4'h0

`endif

// ### src/axil_regs.v
/*
 AXI4-Lite slave holding the configuration digits and a status read-back.
 Assumes a single master on aclk; one write and one read at a time.
*/
`timescale 1ns/1ps
`include "overtravel_map.vh"
module axil_regs (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [15:0] status_word,
   output reg  [3:0]  direction_select_digit,
   output reg  [3:0]  forward_limit_map_digit,
   output reg  [3:0]  reverse_limit_map_digit,
   output reg  [3:0]  overtravel_stop_mode_digit,
   output reg  [3:0]  servo_off_stop_digit,
   output reg  [15:0] emergency_stop_torque
);
   reg        aw_held_reg;
   reg [3:0]  aw_addr_reg;
   reg        w_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   wire       do_write;
   reg        hit;

   // Each channel is taken once, in either order; the response waits for both
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always @* begin
      case (aw_addr_reg)
         `OFF_DIRECTION, `OFF_LIMIT_MAP, `OFF_STOP_MODE, `OFF_ESTOP_TORQUE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg                <= 1'b0;
         aw_addr_reg                <= 4'h0;
         w_held_reg                 <= 1'b0;
         w_data_reg                 <= 32'h0000_0000;
         w_strb_reg                 <= 4'h0;
         s_axi_bvalid               <= 1'b0;
         s_axi_bresp                <= 2'b00;
         direction_select_digit     <= `RST_DIRECTION;
         forward_limit_map_digit    <= `RST_FWD_MAP;
         reverse_limit_map_digit    <= `RST_REV_MAP;
         overtravel_stop_mode_digit <= `RST_OT_MODE;
         servo_off_stop_digit       <= `RST_OFF_MODE;
         emergency_stop_torque      <= `RST_ESTOP_TORQUE;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit ? 2'b00 : 2'b10;
            if (w_strb_reg[0]) begin
               case (aw_addr_reg)
                  `OFF_DIRECTION: direction_select_digit <= w_data_reg[3:0];
                  `OFF_LIMIT_MAP: begin
                     forward_limit_map_digit <= w_data_reg[`LMAP_FWD_LSB +: `DIGIT_W];
                     reverse_limit_map_digit <= w_data_reg[`LMAP_REV_LSB +: `DIGIT_W];
                  end
                  `OFF_STOP_MODE: begin
                     servo_off_stop_digit       <= w_data_reg[`SMODE_OFF_LSB +: `DIGIT_W];
                     overtravel_stop_mode_digit <= w_data_reg[`SMODE_OT_LSB +: `DIGIT_W];
                  end
                  `OFF_ESTOP_TORQUE: emergency_stop_torque[7:0] <= w_data_reg[7:0];
                  default: ;
               endcase
            end
            if (w_strb_reg[1] && aw_addr_reg == `OFF_ESTOP_TORQUE)
               emergency_stop_torque[15:8] <= w_data_reg[15:8];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case ({s_axi_araddr[3:2], 2'b00})
            `OFF_DIRECTION: s_axi_rdata <= {12'h000, status_word[15:0], direction_select_digit};
            `OFF_LIMIT_MAP:
               s_axi_rdata <= {24'h00_0000, reverse_limit_map_digit, forward_limit_map_digit};
            `OFF_STOP_MODE:
               s_axi_rdata <= {24'h00_0000, overtravel_stop_mode_digit, servo_off_stop_digit};
            `OFF_ESTOP_TORQUE: s_axi_rdata <= {16'h0000, emergency_stop_torque};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ### src/sync2.v
/*
 Two-flop synchroniser for a group of pin levels.
 Assumes asynchronous inputs; only the second stage is read outside.
*/
`timescale 1ns/1ps
module sync2 #(
   parameter W = 4
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q,
   input  wire [W-1:0] rst_val
);
   reg [W-1:0] meta_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= rst_val;
         q        <= rst_val;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// ### src/overtravel_stop_control.v
/*
 Direction selection, overtravel gating and stop-mode sequencing for a
 servo drive. Assumes a 40 MHz aclk, limit switches and servo-off and alarm
 levels arriving from pins, and moving and slow speed flags from the same clock domain.
*/
`timescale 1ns/1ps
`include "overtravel_map.vh"
// Summary of operation
// - Digit 0: CCW forward; 1: CW forward
// - Forward limit low permits forward motion
// - Reverse limit low permits reverse motion
// - Forward map default 2; disable forces allowed
// - Reverse map default 3; 8 ignores input
// - Overtravel mode 0 uses servo-off stop
// - Mode 1: torque-limited decel, then clamp
// - Mode 2: torque-limited decel, then coast
// - Stop torque percent, default 800, modes 1-2
// - Off command, alarm, power loss: servo off
// - Off digit: brake-hold, brake-coast, or coast
// - Brake-hold at standstill behaves as coast
module overtravel_stop_control (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        forward_limit_input,
   input  wire        reverse_limit_input,
   input  wire        servo_off_command,
   input  wire        servo_alarm,
   input  wire        power_lost,
   input  wire        cmd_forward,
   input  wire        cmd_reverse,
   input  wire        motor_moving,
   input  wire        motor_slow,
   output reg         run_ccw,
   output reg         run_cw,
   output reg         servo_on,
   output reg         torque_limit_active,
   output reg  [15:0] torque_limit,
   output reg         zero_clamp,
   output reg         dynamic_brake,
   output reg         coast,
   output reg         forward_blocked,
   output reg         reverse_blocked
);
   localparam ST_RUN      = 3'd0;
   localparam ST_OT_DECEL = 3'd1;
   localparam ST_OT_CLAMP = 3'd2;
   localparam ST_OT_COAST = 3'd3;
   localparam ST_OFF_DB   = 3'd4;
   localparam ST_OFF_FREE = 3'd5;

   wire [3:0]  dir_digit;
   wire [3:0]  fwd_map;
   wire [3:0]  rev_map;
   wire [3:0]  ot_mode;
   wire [3:0]  off_mode;
   wire [15:0] estop_torque;
   wire [4:0]  pins_s;
   wire        fwd_lim_s;
   wire        rev_lim_s;
   wire        off_req;
   wire        fwd_prohibit;
   wire        rev_prohibit;
   wire        want_fwd;
   wire        want_rev;
   wire        ot_hit;
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [15:0] status_word;

   axil_regs regs_i (
      .aclk                       (aclk),
      .aresetn                    (aresetn),
      .s_axi_awaddr               (s_axi_awaddr),
      .s_axi_awvalid              (s_axi_awvalid),
      .s_axi_awready              (s_axi_awready),
      .s_axi_wdata                (s_axi_wdata),
      .s_axi_wstrb                (s_axi_wstrb),
      .s_axi_wvalid               (s_axi_wvalid),
      .s_axi_wready               (s_axi_wready),
      .s_axi_bresp                (s_axi_bresp),
      .s_axi_bvalid               (s_axi_bvalid),
      .s_axi_bready               (s_axi_bready),
      .s_axi_araddr               (s_axi_araddr),
      .s_axi_arvalid              (s_axi_arvalid),
      .s_axi_arready              (s_axi_arready),
      .s_axi_rdata                (s_axi_rdata),
      .s_axi_rresp                (s_axi_rresp),
      .s_axi_rvalid               (s_axi_rvalid),
      .s_axi_rready               (s_axi_rready),
      .status_word                (status_word),
      .direction_select_digit     (dir_digit),
      .forward_limit_map_digit    (fwd_map),
      .reverse_limit_map_digit    (rev_map),
      .overtravel_stop_mode_digit (ot_mode),
      .servo_off_stop_digit       (off_mode),
      .emergency_stop_torque      (estop_torque)
   );

   // Open switches read high, so reset fills with prohibiting levels
   sync2 #(.W(5)) pin_sync_i (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({power_lost, servo_alarm, servo_off_command,
                 reverse_limit_input, forward_limit_input}),
      .q       (pins_s),
      .rst_val (5'h1F)
   );

   assign fwd_lim_s = pins_s[0];
   assign rev_lim_s = pins_s[1];
   // Any off source drops the servo; power loss included
   assign off_req   = pins_s[2] | pins_s[3] | pins_s[4];

   // A disabled map digit behaves as the input shorted low
   assign fwd_prohibit = (fwd_map == `RST_FWD_MAP) & fwd_lim_s;
   assign rev_prohibit = (rev_map != `LIMIT_UNUSED) & rev_lim_s;

   // Only the prohibited direction is refused; the other stays live
   assign want_fwd = cmd_forward & ~cmd_reverse & ~fwd_prohibit;
   assign want_rev = cmd_reverse & ~cmd_forward & ~rev_prohibit;
   assign ot_hit   = motor_moving & ((cmd_forward & fwd_prohibit) |
                                     (cmd_reverse & rev_prohibit));

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (off_req)
               state_next = ST_OFF_DB;
            else if (ot_hit) begin
               case (ot_mode)
                  `OT_SERVO_OFF: state_next = ST_OFF_DB;
                  `OT_DECEL_CLAMP, `OT_DECEL_COAST: state_next = ST_OT_DECEL;
                  default: state_next = ST_OFF_DB;
               endcase
            end
         end
         ST_OT_DECEL: begin
            if (off_req)
               state_next = ST_OFF_DB;
            else if (!motor_moving)
               state_next = (ot_mode == `OT_DECEL_COAST) ? ST_OT_COAST
                                                         : ST_OT_CLAMP;
         end
         ST_OT_CLAMP, ST_OT_COAST: begin
            // Release once the limit clears or a command for a permitted direction arrives
            if (off_req)
               state_next = ST_OFF_DB;
            else if (!(fwd_prohibit | rev_prohibit) || want_fwd || want_rev)
               state_next = ST_RUN;
         end
         ST_OFF_DB: begin
            if (!motor_moving && off_mode == `OFF_DB_COAST)
               state_next = ST_OFF_FREE;
            else if (!off_req && !ot_hit && !motor_moving)
               state_next = ST_RUN;
         end
         ST_OFF_FREE: begin
            if (!off_req && !motor_moving)
               state_next = ST_RUN;
         end
         default: state_next = ST_RUN;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn)
         state_reg <= ST_RUN;
      else
         state_reg <= state_next;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         run_ccw             <= 1'b0;
         run_cw              <= 1'b0;
         servo_on            <= 1'b0;
         torque_limit_active <= 1'b0;
         torque_limit        <= 16'h0000;
         zero_clamp          <= 1'b0;
         dynamic_brake       <= 1'b0;
         coast               <= 1'b1;
         forward_blocked     <= 1'b0;
         reverse_blocked     <= 1'b0;
         status_word         <= 16'h0000;
      end else begin
         forward_blocked <= fwd_prohibit;
         reverse_blocked <= rev_prohibit;
         // Forward maps to CCW unless the direction digit reverses it
         if (state_next == ST_RUN) begin
            run_ccw <= (dir_digit == `RST_DIRECTION) ? want_fwd : want_rev;
            run_cw  <= (dir_digit == `RST_DIRECTION) ? want_rev : want_fwd;
         end else begin
            run_ccw <= 1'b0;
            run_cw  <= 1'b0;
         end
         servo_on <= (state_next == ST_RUN) || (state_next == ST_OT_DECEL) ||
                     (state_next == ST_OT_CLAMP);
         torque_limit_active <= (state_next == ST_OT_DECEL);
         torque_limit        <= (state_next == ST_OT_DECEL) ? estop_torque : 16'h0000;
         zero_clamp          <= (state_next == ST_OT_CLAMP);
         // Brake has no force at standstill, so hold mode reads as coast
         dynamic_brake <= (state_next == ST_OFF_DB) && (off_mode != `OFF_COAST) &&
                          motor_moving && !motor_slow;
         coast <= (state_next == ST_OT_COAST) || (state_next == ST_OFF_FREE) ||
                  ((state_next == ST_OFF_DB) &&
                   ((off_mode == `OFF_COAST) || !motor_moving || motor_slow));
         status_word <= {8'h00, 1'b0, state_next, 2'b00, rev_prohibit, fwd_prohibit};
      end
   end
endmodule

// ### sim/ots_chk.sv
/*
 Checker for overtravel_stop_control, bound to its top ports.
 Assumes aclk with active-low synchronous aresetn.
*/
`timescale 1ns/1ps
module ots_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic servo_off_command,
   input wire logic servo_alarm,
   input wire logic power_lost,
   input wire logic cmd_forward,
   input wire logic cmd_reverse,
   input wire logic run_ccw,
   input wire logic run_cw,
   input wire logic servo_on,
   input wire logic torque_limit_active,
   input wire logic zero_clamp,
   input wire logic dynamic_brake,
   input wire logic coast,
   input wire logic forward_blocked,
   input wire logic reverse_blocked
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   one_direction_a: assert property (!(run_ccw && run_cw))
      else $error("both run outputs high");
   both_cmd_idle_a: assert property (cmd_forward && cmd_reverse |=> !run_ccw && !run_cw)
      else $error("run with both commands high");
   idle_cmd_still_a: assert property (!cmd_forward && !cmd_reverse |=> !run_ccw && !run_cw)
      else $error("run without a command");
   off_event_stops_a: assert property ((servo_off_command || servo_alarm || power_lost) [*4] |=> !servo_on)
      else $error("servo stays on after an off event");
   off_no_run_a: assert property (!servo_on |-> !run_ccw && !run_cw)
      else $error("run while servo off");
   off_stop_kind_a: assert property (!servo_on |-> dynamic_brake || coast)
      else $error("servo off without brake or coast");
   clamp_holds_a: assert property (zero_clamp |-> servo_on && !coast)
      else $error("zero clamp while coasting or off");
   decel_servo_on_a: assert property (torque_limit_active |-> servo_on)
      else $error("torque limited stop with servo off");
   both_blocked_a: assert property ((forward_blocked && reverse_blocked) [*2] |-> !run_ccw && !run_cw)
      else $error("run with both directions blocked");

   cover property (torque_limit_active);
   cover property (zero_clamp);
   cover property (dynamic_brake ##1 coast);
endmodule

// ### sim/motor_switch_model.sv
/*
 Far-side model: two limit switches and a motor whose speed ramps
 with the run outputs. Assumes the run outputs are registered on aclk.
*/
`timescale 1ns/1ps
module motor_switch_model (
   input  wire logic aclk,
   input  wire logic run_ccw,
   input  wire logic run_cw,
   input  wire logic fwd_hit,
   input  wire logic rev_hit,
   output logic      forward_limit_input = 1'b0,
   output logic      reverse_limit_input = 1'b0,
   output logic      motor_moving,
   output logic      motor_slow
);
   logic [3:0] speed = 4'h0;
   // Ramp both ways so stop logic sees a real deceleration
   always @(posedge aclk) begin
      forward_limit_input <= fwd_hit;
      reverse_limit_input <= rev_hit;
      if ((run_ccw || run_cw) && speed != 4'h8)
         speed <= speed + 4'h1;
      else if (!(run_ccw || run_cw) && speed != 4'h0)
         speed <= speed - 4'h1;
   end
   assign motor_moving = speed != 4'h0;
   assign motor_slow   = speed == 4'h1;
endmodule

// ### sim/overtravel_stop_control_bench.sv
/*
 Bench for overtravel_stop_control: AXI4-Lite tasks and directed tests.
 Assumes the far-side model supplies limit pins and motor speed.
*/
`timescale 1ns/1ps
module overtravel_stop_control_bench;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, fwd_hit, rev_hit;
   logic        servo_off_command, servo_alarm, power_lost, cmd_forward, cmd_reverse;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, v;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         forward_limit_input, reverse_limit_input, motor_moving, motor_slow;
   wire         run_ccw, run_cw, servo_on, torque_limit_active, zero_clamp;
   wire         dynamic_brake, coast, forward_blocked, reverse_blocked;
   wire  [15:0] torque_limit;
   integer      miscompares = 0, cmp_count = 0, i;

   overtravel_stop_control dut (.*);
   motor_switch_model far (.*);

   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count++;
         if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   task wt(input integer n);
      repeat (n) @(posedge aclk);
   endtask

   task drive(input f, input r);
      begin
         cmd_forward <= f;
         cmd_reverse <= r;
         wt(2);
      end
   endtask

   task wr(input [3:0] a, input [31:0] d);
      integer n;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
               s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
               chk("bresp", s_axi_bresp, 32'h0000_0000);
               s_axi_bready <= 1'b0;
               n = 100;
            end
         end
         if (n < 100)
            chk("write answer", 32'h0000_0000, 32'h0000_0001);
      end
   endtask

   task rd(input [3:0] a, output [31:0] d);
      integer n;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         d = 32'h0000_0000;
         for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
               s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               d = s_axi_rdata;
               s_axi_rready <= 1'b0;
               n = 100;
            end
         end
         if (n < 100)
            chk("read answer", 32'h0000_0000, 32'h0000_0001);
      end
   endtask

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      summarize;
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
      {s_axi_rready, fwd_hit, rev_hit, servo_off_command, servo_alarm} = 5'h00;
      {power_lost, cmd_forward, cmd_reverse} = 3'h0;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wdata = 32'h0000_0000;
      wt(16);
      aresetn <= 1'b1;
      wt(4);
      rd(4'h0, v);
      chk("direction digit", v[3:0], 32'h0000_0000);
      rd(4'h4, v);
      chk("limit maps", v, 32'h0000_0032);
      rd(4'h8, v);
      chk("stop digits", v, 32'h0000_0000);
      rd(4'hC, v);
      chk("stop torque", v, 32'h0000_0320);
      $display("test reset values done");
      for (i = 0; i < 2; i++) begin
         wr(4'h0, i);
         drive(1, 0);
         chk("fwd ccw", run_ccw, i == 0);
         chk("fwd cw", run_cw, i == 1);
         drive(0, 1);
         chk("rev ccw", run_ccw, i == 1);
         drive(0, 0);
         wt(12);
      end
      wr(4'h0, 32'h0000_0000);
      $display("test direction done");
      for (i = 0; i < 2; i++) begin
         fwd_hit <= (i == 0);
         rev_hit <= (i == 1);
         wt(6);
         chk("fwd blocked", forward_blocked, i == 0);
         chk("rev blocked", reverse_blocked, i == 1);
         drive(1, 0);
         chk("fwd run", run_ccw, i == 1);
         drive(0, 1);
         chk("rev run", run_cw, i == 0);
         drive(0, 0);
         fwd_hit <= 1'b0;
         rev_hit <= 1'b0;
         wt(20);
      end
      wr(4'h4, 32'h0000_0080);
      fwd_hit <= 1'b1;
      rev_hit <= 1'b1;
      wt(6);
      chk("fwd unmapped", forward_blocked, 32'h0000_0000);
      chk("rev unmapped", reverse_blocked, 32'h0000_0000);
      drive(1, 0);
      chk("fwd free run", run_ccw, 32'h0000_0001);
      drive(0, 0);
      fwd_hit <= 1'b0;
      rev_hit <= 1'b0;
      wr(4'h4, 32'h0000_0032);
      wt(12);
      $display("test limits done");
      wr(4'hC, 32'h0000_012C);
      for (i = 0; i < 3; i++) begin
         wr(4'h8, i * 16);
         drive(1, 0);
         wt(10);
         fwd_hit <= 1'b1;
         wt(5);
         chk("ot run", run_ccw, 32'h0000_0000);
         if (i == 0)
            chk("ot brake", dynamic_brake, 32'h0000_0001);
         else begin
            chk("ot torque on", torque_limit_active, 32'h0000_0001);
            chk("ot torque", torque_limit, 32'h0000_012C);
         end
         wt(20);
         chk("ot clamp", zero_clamp, i == 1);
         chk("ot coast", coast, i == 2);
         drive(0, 0);
         fwd_hit <= 1'b0;
         wt(20);
      end
      $display("test overtravel done");
      for (i = 0; i < 3; i++) begin
         wr(4'h8, i);
         drive(1, 0);
         wt(10);
         servo_off_command <= (i == 0);
         servo_alarm <= (i == 1);
         power_lost <= (i == 2);
         wt(5);
         chk("servo off", servo_on, 32'h0000_0000);
         chk("off brake", dynamic_brake, i != 2);
         chk("off coast", coast, i == 2);
         wt(20);
         chk("stopped coast", coast, 32'h0000_0001);
         {servo_off_command, servo_alarm, power_lost} <= 3'h0;
         drive(0, 0);
         wt(10);
         chk("servo back", servo_on, 32'h0000_0001);
      end
      $display("test servo off done");
      summarize;
   end
endmodule

bind overtravel_stop_control ots_chk chk (.*);
